/* File: design/lsuc_pkg.sv */
package lsuc_pkg;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int LSUC_XLEN = 64;
  localparam int LSUC_PA_W = 34;
  localparam int LSUC_INSTR_W = 16;
  localparam int LSUC_IDX_W = 8;
  localparam int LSUC_CTL_STC_BIT = 7;
  localparam int LSUC_CTL_NOPROBE_BIT = 8;
  localparam int LSUC_CTL_RR_BIT = 9;
  localparam int LSUC_CTL_DATA_CACHE_ENABLE_BIT = 10;
  localparam int LSUC_CTL_FHIT_BIT = 11;
  localparam int LSUC_CTL_SIZE_BIT = 12;
  localparam int LSUC_CTL_FTAG_BIT = 13;
  localparam int LSUC_CTL_NOPAR_BIT = 14;
  localparam int LSUC_CTL_DINV_BIT = 15;
  localparam int LSUC_ALT_LSB = 3;
  localparam int LSUC_ALT_MSB = 4;
  localparam int LSUC_ALT_INSTR_BIT = 14;
  localparam int LSUC_CC_HALF = 32;
  localparam int LSUC_CC_ENA_BIT = 32;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [1:0] LSUC_HIDE_CYCLES = 2'h2;
  localparam logic [31:0] LSUC_CC_STEP = 32'h00000001;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LSUC_MODE_KERNEL = 2'h0,
    LSUC_MODE_EXEC = 2'h1,
    LSUC_MODE_SUPER = 2'h2,
    LSUC_MODE_USER = 2'h3
  } lsuc_mode_e;

  typedef enum logic [1:0] {
    LSUC_IPR_LSU_CTL = 2'h0,
    LSUC_IPR_ALTERNATE_ACCESS_MODE = 2'h1,
    LSUC_IPR_CC = 2'h2,
    LSUC_IPR_CYCLE_COUNTER_CONTROL = 2'h3
  } lsuc_ipr_e;

  typedef struct packed {
    logic wr;
    logic rd;
    lsuc_ipr_e sel;
    logic [LSUC_XLEN-1:0] data;
  } lsuc_ipr_req_s;

  typedef struct packed {
    logic store_cond_relax;
    logic noprobe_noncacheable_mode;
    logic xlate_round_robin_sel;
    logic data_cache_enable;
    logic data_cache_force_hit;
    logic data_cache_size_sel;
    logic forced_tag_error;
    logic parity_check_disable;
    logic double_invalidate;
  } lsuc_ctl_s;

  localparam lsuc_ctl_s LSUC_CTL_RST = '0;
  localparam logic [LSUC_XLEN-1:0] LSUC_ZERO64 = 64'h0000000000000000;

  function automatic lsuc_ctl_s lsuc_unpack_ctl(input logic [LSUC_XLEN-1:0] v);
    lsuc_ctl_s c;
    c.store_cond_relax = v[LSUC_CTL_STC_BIT];
    c.noprobe_noncacheable_mode = v[LSUC_CTL_NOPROBE_BIT];
    c.xlate_round_robin_sel = v[LSUC_CTL_RR_BIT];
    c.data_cache_enable = v[LSUC_CTL_DATA_CACHE_ENABLE_BIT];
    c.data_cache_force_hit = v[LSUC_CTL_FHIT_BIT];
    c.data_cache_size_sel = v[LSUC_CTL_SIZE_BIT];
    c.forced_tag_error = v[LSUC_CTL_FTAG_BIT];
    c.parity_check_disable = v[LSUC_CTL_NOPAR_BIT];
    c.double_invalidate = v[LSUC_CTL_DINV_BIT];
    return c;
  endfunction : lsuc_unpack_ctl

endpackage : lsuc_pkg

/* File: design/lsuc_cycle_counter.sv */
`timescale 1ns/1ps
module lsuc_cycle_counter
  import lsuc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Writes
  input wire logic wr_offset_in,
  input wire logic wr_ctl_in,
  input wire logic [LSUC_XLEN-1:0] src_data_in,
  // State
  output logic [LSUC_XLEN-1:0] cc_value_out,
  output logic counting_out
);

  typedef struct packed {
    logic [LSUC_CC_HALF-1:0] offset;
    logic [LSUC_CC_HALF-1:0] count;
    logic ena;
  } lsuc_cc_s;

  lsuc_cc_s st_q;
  lsuc_cc_s st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.ena) begin
      st_d.count = st_q.count + LSUC_CC_STEP;
    end
    if (wr_offset_in) begin
      st_d.offset = src_data_in[LSUC_XLEN-1:LSUC_CC_HALF];
    end
    if (wr_ctl_in) begin
      st_d.count = src_data_in[LSUC_CC_HALF-1:0];
      st_d.ena = src_data_in[LSUC_CC_ENA_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cc_value_out = {st_q.offset, st_q.count};
  assign counting_out = st_q.ena;

endmodule : lsuc_cycle_counter

/* File: design/lsuc_inval_ctl.sv */
`timescale 1ns/1ps
module lsuc_inval_ctl
  import lsuc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Pins
  input wire logic [1:0] inval_req_in,
  input wire logic [LSUC_IDX_W-1:0] inval_addr_in,
  // Control
  input wire logic double_en_in,
  // Cache side
  output logic [1:0] blk_inval_out,
  output logic [LSUC_IDX_W-1:0] blk_index_out
);

  // Three-stage synchronisers; only stages two and three are compared.
  typedef struct packed {
    logic [2:0][1:0] req_sync;
    logic [2:0][LSUC_IDX_W-1:0] adr_sync;
    logic [1:0] req_seen;
    logic [1:0] blk;
    logic [LSUC_IDX_W-1:0] idx;
  } lsuc_inv_s;

  lsuc_inv_s st_q;
  lsuc_inv_s st_d;
  logic [1:0] agreed;
  logic [1:0] rise;

  always_comb begin
    st_d = st_q;
    st_d.req_sync = {st_q.req_sync[1:0], inval_req_in};
    st_d.adr_sync = {st_q.adr_sync[1:0], inval_addr_in};
    agreed = st_q.req_sync[1] & st_q.req_sync[2];
    rise = agreed & ~st_q.req_seen;
    // Each line keeps its own agreed level, so noise on one line cannot re-arm the other.
    st_d.req_seen = agreed | (st_q.req_seen & (st_q.req_sync[1] | st_q.req_sync[2]));
    st_d.blk = {rise[1] | (rise[0] & double_en_in), rise[0]};
    if (rise != 2'h0) begin
      st_d.idx = st_q.adr_sync[2];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign blk_inval_out = st_q.blk;
  assign blk_index_out = st_q.idx;

endmodule : lsuc_inval_ctl

/* File: design/lsuc_regs.sv */
`timescale 1ns/1ps
module lsuc_regs
  import lsuc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Processor register moves
  input wire lsuc_ipr_req_s ipr_req_in,
  input wire logic read_cycle_count_instr_in,
  output logic [LSUC_XLEN-1:0] read_data_out,
  output logic read_valid_out,
  // Locked operations
  input wire logic locked_op_valid_in,
  input wire logic [LSUC_PA_W-1:0] locked_op_addr_in,
  input wire logic cond_store_to_biu_in,
  output logic lock_conforming_out,
  output logic cond_result_unpredictable_out,
  output logic mem_pipe_restart_out,
  output logic dc_line_inval_out,
  output logic [LSUC_PA_W-1:0] dc_line_addr_out,
  output logic inval_hidden_out,
  // External reads
  input wire logic ext_read_valid_in,
  input wire logic ext_read_probed_in,
  input wire logic ext_read_cacheable_in,
  output logic ext_read_noncacheable_out,
  // Cache and translation buffer steering
  output logic dtb_round_robin_out,
  output logic dcache_enable_out,
  output logic dcache_flush_out,
  output logic dcache_size_16k_out,
  output logic icache_parity_check_en_out,
  output logic dcache_parity_check_en_out,
  // Data references and fills
  input wire logic dstream_ref_valid_in,
  input wire logic dcache_tag_match_in,
  output logic dcache_hit_out,
  input wire logic fill_valid_in,
  input wire logic fill_tag_parity_in,
  output logic fill_tag_parity_out,
  // External invalidate pins
  input wire logic [1:0] external_invalidate_request_in,
  input wire logic [LSUC_IDX_W-1:0] invalidate_address_in,
  output logic [1:0] dc_block_inval_out,
  output logic [LSUC_IDX_W-1:0] dc_block_index_out,
  // Privileged memory access mode
  input wire logic priv_mem_valid_in,
  input wire logic [LSUC_INSTR_W-1:0] priv_instr_in,
  input wire lsuc_mode_e current_mode_in,
  output lsuc_mode_e access_mode_out,
  // Cycle counter
  output logic cycle_counting_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    lsuc_ctl_s ctl;
    lsuc_mode_e alternate_access_mode;
    logic [LSUC_XLEN-1:0] rd_data;
    logic rd_valid;
    logic flush;
    logic line_inval;
    logic [LSUC_PA_W-1:0] line_addr;
    logic [1:0] hide_cnt;
    logic restart;
    logic noncacheable;
    logic hit;
    logic fill_par;
    lsuc_mode_e acc_mode;
  } lsuc_st_s;

  lsuc_st_s st_q;
  lsuc_st_s st_d;
  logic wr_ctl;
  logic wr_alt;
  logic wr_cc;
  logic wr_cycle_counter_control;
  logic [LSUC_XLEN-1:0] cc_value;
  logic cc_counting;

  assign wr_ctl = ipr_req_in.wr && (ipr_req_in.sel == LSUC_IPR_LSU_CTL);
  assign wr_alt = ipr_req_in.wr && (ipr_req_in.sel == LSUC_IPR_ALTERNATE_ACCESS_MODE);
  assign wr_cc = ipr_req_in.wr && (ipr_req_in.sel == LSUC_IPR_CC);
  assign wr_cycle_counter_control = ipr_req_in.wr && (ipr_req_in.sel == LSUC_IPR_CYCLE_COUNTER_CONTROL);

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  lsuc_cycle_counter u_cc (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_offset_in(wr_cc),
    .wr_ctl_in(wr_cycle_counter_control),
    .src_data_in(ipr_req_in.data),
    .cc_value_out(cc_value),
    .counting_out(cc_counting)
  );

  lsuc_inval_ctl u_inv (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .inval_req_in(external_invalidate_request_in),
    .inval_addr_in(invalidate_address_in),
    .double_en_in(st_q.ctl.double_invalidate),
    .blk_inval_out(dc_block_inval_out),
    .blk_index_out(dc_block_index_out)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.flush = 1'b0;
    st_d.line_inval = 1'b0;
    st_d.restart = 1'b0;
    if (wr_ctl) begin
      st_d.ctl = lsuc_unpack_ctl(ipr_req_in.data);
      st_d.flush = !ipr_req_in.data[LSUC_CTL_DATA_CACHE_ENABLE_BIT];
    end
    if (wr_alt) begin
      st_d.alternate_access_mode = lsuc_mode_e'(ipr_req_in.data[LSUC_ALT_MSB:LSUC_ALT_LSB]);
    end
    st_d.rd_valid = ipr_req_in.rd || read_cycle_count_instr_in;
    if (read_cycle_count_instr_in || (ipr_req_in.rd && (ipr_req_in.sel == LSUC_IPR_CC))) begin
      st_d.rd_data = cc_value;
    end else if (ipr_req_in.rd) begin
      // Write-only registers read as zero.
      st_d.rd_data = LSUC_ZERO64;
    end
    if (st_q.hide_cnt != 2'h0) begin
      st_d.hide_cnt = st_q.hide_cnt - 2'h1;
    end
    if (st_q.ctl.store_cond_relax && locked_op_valid_in) begin
      st_d.line_inval = 1'b1;
      st_d.line_addr = locked_op_addr_in;
      st_d.hide_cnt = LSUC_HIDE_CYCLES;
    end
    st_d.restart = st_q.ctl.store_cond_relax && cond_store_to_biu_in;
    if (ext_read_valid_in) begin
      st_d.noncacheable = !ext_read_cacheable_in ||
        (st_q.ctl.noprobe_noncacheable_mode && !ext_read_probed_in);
    end
    if (dstream_ref_valid_in) begin
      st_d.hit = st_q.ctl.data_cache_force_hit || (st_q.ctl.data_cache_enable && dcache_tag_match_in);
    end
    if (fill_valid_in) begin
      st_d.fill_par = fill_tag_parity_in ^ st_q.ctl.forced_tag_error;
    end
    if (priv_mem_valid_in) begin
      st_d.acc_mode = priv_instr_in[LSUC_ALT_INSTR_BIT] ? st_q.alternate_access_mode : current_mode_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign read_data_out = st_q.rd_data;
  assign read_valid_out = st_q.rd_valid;
  assign lock_conforming_out = !st_q.ctl.store_cond_relax;
  assign cond_result_unpredictable_out = st_q.ctl.store_cond_relax;
  assign mem_pipe_restart_out = st_q.restart;
  assign dc_line_inval_out = st_q.line_inval;
  assign dc_line_addr_out = st_q.line_addr;
  // The cache must not let lookups in this window see the invalidated line as gone.
  assign inval_hidden_out = (st_q.hide_cnt != 2'h0);
  assign ext_read_noncacheable_out = st_q.noncacheable;
  assign dtb_round_robin_out = st_q.ctl.xlate_round_robin_sel;
  assign dcache_enable_out = st_q.ctl.data_cache_enable;
  assign dcache_flush_out = st_q.flush;
  assign dcache_size_16k_out = st_q.ctl.data_cache_size_sel;
  assign icache_parity_check_en_out = !st_q.ctl.parity_check_disable;
  assign dcache_parity_check_en_out = !st_q.ctl.parity_check_disable;
  assign dcache_hit_out = st_q.hit;
  assign fill_tag_parity_out = st_q.fill_par;
  assign access_mode_out = st_q.acc_mode;
  assign cycle_counting_out = cc_counting;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_lock_in_relax;
    st_q.ctl.store_cond_relax && locked_op_valid_in;
  endsequence

  sequence s_hidden_window;
    dc_line_inval_out ##0 inval_hidden_out [*2];
  endsequence

  chk_lock_relax_inval: assert property (s_lock_in_relax |=> s_hidden_window)
    else $error("lock op under relaxation did not invalidate and hide for two cycles");

  chk_lock_line_addr: assert property (s_lock_in_relax |=> dc_line_addr_out == $past(locked_op_addr_in))
    else $error("invalidated line address differs from lock op address");

  chk_lock_strict: assert property (!st_q.ctl.store_cond_relax |-> lock_conforming_out ##1 !dc_line_inval_out)
    else $error("strict lock mode produced a line invalidate");

  chk_restart_relax: assert property (cond_store_to_biu_in |=> mem_pipe_restart_out == $past(st_q.ctl.store_cond_relax))
    else $error("pipeline restart does not follow relaxation bit");

  chk_flush_clear: assert property (wr_ctl && !ipr_req_in.data[LSUC_CTL_DATA_CACHE_ENABLE_BIT]
    |=> dcache_flush_out && !dcache_enable_out ##1 !dcache_flush_out)
    else $error("clearing cache enable did not pulse flush once");

  chk_force_hit: assert property (dstream_ref_valid_in && st_q.ctl.data_cache_force_hit |=> dcache_hit_out)
    else $error("force hit reference missed");

  chk_noprobe_mode: assert property (ext_read_valid_in && ext_read_cacheable_in && !ext_read_probed_in
    |=> ext_read_noncacheable_out == $past(st_q.ctl.noprobe_noncacheable_mode))
    else $error("unprobed read cacheability wrong");

  chk_fill_parity: assert property (fill_valid_in
    |=> fill_tag_parity_out == ($past(fill_tag_parity_in) ^ $past(st_q.ctl.forced_tag_error)))
    else $error("fill tag parity not corrupted as configured");

  chk_alternate_access_mode_use: assert property (priv_mem_valid_in && priv_instr_in[LSUC_ALT_INSTR_BIT]
    |=> access_mode_out == $past(st_q.alternate_access_mode))
    else $error("alternate access mode not applied");

  chk_cc_increment: assert property (cc_counting && !wr_cycle_counter_control
    |=> cc_value[LSUC_CC_HALF-1:0] == $past(cc_value[LSUC_CC_HALF-1:0]) + LSUC_CC_STEP)
    else $error("cycle count did not step by one");

  chk_cc_upper_write: assert property (wr_cc && !wr_cycle_counter_control && !cc_counting
    |=> cc_value == {$past(ipr_req_in.data[LSUC_XLEN-1:LSUC_CC_HALF]), $past(cc_value[LSUC_CC_HALF-1:0])})
    else $error("offset write disturbed the count or missed the offset");

  chk_cycle_counter_control_write: assert property (wr_cycle_counter_control && !wr_cc
    |=> cycle_counting_out == $past(ipr_req_in.data[LSUC_CC_ENA_BIT])
        && cc_value[LSUC_XLEN-1:LSUC_CC_HALF] == $past(cc_value[LSUC_XLEN-1:LSUC_CC_HALF]))
    else $error("control write mishandled enable or offset");

  chk_cc_read: assert property (read_cycle_count_instr_in |=> read_valid_out && read_data_out == $past(cc_value))
    else $error("counter read returned wrong value");

  chk_double_invalidate: assert property (st_q.ctl.double_invalidate && $stable(st_q.ctl.double_invalidate)
    && dc_block_inval_out[0] |-> dc_block_inval_out[1])
    else $error("double invalidate hit only one block");

  chk_reset_clears: assert property (!$past(rst_n_in) |->
    !st_q.ctl.store_cond_relax && !st_q.ctl.noprobe_noncacheable_mode)
    else $error("reset left relaxation or noprobe mode set");

  chk_relax_write: assert property (wr_ctl |=>
    cond_result_unpredictable_out == $past(ipr_req_in.data[LSUC_CTL_STC_BIT]))
    else $error("relaxation bit does not follow control write");

  chk_rr_select: assert property (wr_ctl |=>
    dtb_round_robin_out == $past(ipr_req_in.data[LSUC_CTL_RR_BIT]))
    else $error("round robin select does not follow control write");

  chk_size_select: assert property (wr_ctl |=>
    dcache_size_16k_out == $past(ipr_req_in.data[LSUC_CTL_SIZE_BIT]))
    else $error("cache size select does not follow control write");

  chk_parity_gate: assert property (wr_ctl |=>
    {icache_parity_check_en_out, dcache_parity_check_en_out} == {2{!$past(ipr_req_in.data[LSUC_CTL_NOPAR_BIT])}})
    else $error("parity check enables do not follow disable bit");

  chk_enable_set: assert property (wr_ctl && ipr_req_in.data[LSUC_CTL_DATA_CACHE_ENABLE_BIT] |=>
    dcache_enable_out && !dcache_flush_out)
    else $error("setting cache enable did not enable without flush");

  chk_probed_cached: assert property (ext_read_valid_in && ext_read_cacheable_in && ext_read_probed_in |=>
    !ext_read_noncacheable_out)
    else $error("probed cacheable read marked noncacheable");

  chk_alternate_access_mode_write: assert property (wr_alt |=>
    st_q.alternate_access_mode == lsuc_mode_e'($past(ipr_req_in.data[LSUC_ALT_MSB:LSUC_ALT_LSB])))
    else $error("alternate mode field not stored as written");

  chk_own_mode: assert property (priv_mem_valid_in && !priv_instr_in[LSUC_ALT_INSTR_BIT] |=>
    access_mode_out == $past(current_mode_in))
    else $error("access without alternate bit used the wrong mode");

  chk_cc_lower_write: assert property (wr_cycle_counter_control |=>
    cc_value[LSUC_CC_HALF-1:0] == $past(ipr_req_in.data[LSUC_CC_HALF-1:0]))
    else $error("control write did not load the running count");

  chk_cc_wrap: assert property (cc_counting && !wr_cc && !wr_cycle_counter_control && (&cc_value[LSUC_CC_HALF-1:0]) |=>
    cc_value[LSUC_CC_HALF-1:0] == '0 && $stable(cc_value[LSUC_XLEN-1:LSUC_CC_HALF]))
    else $error("count wrap disturbed the offset or missed zero");

  chk_ipr_cc_read: assert property (ipr_req_in.rd && ipr_req_in.sel == LSUC_IPR_CC |=>
    read_valid_out && read_data_out == $past(cc_value))
    else $error("privileged counter read returned wrong value");

  chk_inval_once: assert property (dc_block_inval_out[0] |=> !dc_block_inval_out[0])
    else $error("one pin edge invalidated block zero twice");

endmodule : lsuc_regs

/* File: verification/test_lsuc_regs.sv */
`timescale 1ns/1ps
module test_lsuc_regs
  import lsuc_pkg::*;
();

  // ---------------------------------------------------------------
  // Stimulus, observed outputs and device
  // ---------------------------------------------------------------
  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  lsuc_ipr_req_s ipr_req_in = '0;
  logic read_cycle_count_instr_in = 1'h0;
  logic locked_op_valid_in = 1'h0;
  logic [LSUC_PA_W-1:0] locked_op_addr_in = '0;
  logic cond_store_to_biu_in = 1'h0;
  logic ext_read_valid_in = 1'h0;
  logic ext_read_probed_in = 1'h0;
  logic ext_read_cacheable_in = 1'h0;
  logic dstream_ref_valid_in = 1'h0;
  logic dcache_tag_match_in = 1'h0;
  logic fill_valid_in = 1'h0;
  logic fill_tag_parity_in = 1'h0;
  logic [1:0] external_invalidate_request_in = 2'h0;
  logic [LSUC_IDX_W-1:0] invalidate_address_in = '0;
  logic priv_mem_valid_in = 1'h0;
  logic [LSUC_INSTR_W-1:0] priv_instr_in = '0;
  lsuc_mode_e current_mode_in = LSUC_MODE_KERNEL;
  logic [LSUC_XLEN-1:0] read_data_out;
  logic [LSUC_PA_W-1:0] dc_line_addr_out;
  logic [1:0] dc_block_inval_out;
  logic [LSUC_IDX_W-1:0] dc_block_index_out;
  lsuc_mode_e access_mode_out;
  logic read_valid_out, lock_conforming_out, cond_result_unpredictable_out, mem_pipe_restart_out;
  logic dc_line_inval_out, inval_hidden_out, ext_read_noncacheable_out, dtb_round_robin_out;
  logic dcache_enable_out, dcache_flush_out, dcache_size_16k_out, icache_parity_check_en_out;
  logic dcache_parity_check_en_out, dcache_hit_out, fill_tag_parity_out, cycle_counting_out;
  int bad_count = 0;
  int n_checks = 0;

  lsuc_regs uut (
    .clk_sys_in, .rst_n_in, .ipr_req_in, .read_cycle_count_instr_in, .read_data_out, .read_valid_out,
    .locked_op_valid_in, .locked_op_addr_in, .cond_store_to_biu_in, .lock_conforming_out,
    .cond_result_unpredictable_out, .mem_pipe_restart_out, .dc_line_inval_out, .dc_line_addr_out,
    .inval_hidden_out, .ext_read_valid_in, .ext_read_probed_in, .ext_read_cacheable_in,
    .ext_read_noncacheable_out, .dtb_round_robin_out, .dcache_enable_out, .dcache_flush_out,
    .dcache_size_16k_out, .icache_parity_check_en_out, .dcache_parity_check_en_out,
    .dstream_ref_valid_in, .dcache_tag_match_in, .dcache_hit_out, .fill_valid_in, .fill_tag_parity_in,
    .fill_tag_parity_out, .external_invalidate_request_in, .invalidate_address_in, .dc_block_inval_out,
    .dc_block_index_out, .priv_mem_valid_in, .priv_instr_in, .current_mode_in, .access_mode_out,
    .cycle_counting_out
  );

  always #2 clk_sys_in = ~clk_sys_in;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  // Request is held for exactly one taking edge, then released.
  task automatic ipr(input logic w, input logic r, input lsuc_ipr_e s, input logic [63:0] d);
    @(posedge clk_sys_in);
    ipr_req_in <= '{wr: w, rd: r, sel: s, data: d};
    @(posedge clk_sys_in);
    ipr_req_in <= '0;
  endtask : ipr

  task automatic wr_ctl(input logic [63:0] d);
    ipr(1'h1, 1'h0, LSUC_IPR_LSU_CTL, d);
    #1;
  endtask : wr_ctl

  task automatic rd_chk(input lsuc_ipr_e s, input logic [63:0] e);
    ipr(1'h0, 1'h1, s, 64'h0);
    #1;
    chk("read_valid", 64'h1, 64'(read_valid_out));
    chk("read_data", e, read_data_out);
  endtask : rd_chk

  task automatic lookups(input logic m, input logic p, input logic c, input logic [2:0] e);
    @(posedge clk_sys_in);
    dstream_ref_valid_in <= 1'h1;
    dcache_tag_match_in <= m;
    fill_valid_in <= 1'h1;
    fill_tag_parity_in <= p;
    ext_read_valid_in <= 1'h1;
    ext_read_probed_in <= p;
    ext_read_cacheable_in <= c;
    @(posedge clk_sys_in);
    dstream_ref_valid_in <= 1'h0;
    fill_valid_in <= 1'h0;
    ext_read_valid_in <= 1'h0;
    #1;
    chk("dcache_hit", 64'(e[2]), 64'(dcache_hit_out));
    chk("fill_parity", 64'(e[1]), 64'(fill_tag_parity_out));
    chk("noncacheable", 64'(e[0]), 64'(ext_read_noncacheable_out));
  endtask : lookups

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_and_ctl();
    chk("lock_conforming", 64'h1, 64'(lock_conforming_out));
    chk("unpredictable", 64'h0, 64'(cond_result_unpredictable_out));
    chk("parity_en", 64'h3, {62'h0, icache_parity_check_en_out, dcache_parity_check_en_out});
    wr_ctl((64'h1 << LSUC_CTL_RR_BIT) | (64'h1 << LSUC_CTL_DATA_CACHE_ENABLE_BIT) | (64'h1 << LSUC_CTL_SIZE_BIT)
      | (64'h1 << LSUC_CTL_NOPAR_BIT));
    chk("ctl_set", 64'h7, {61'h0, dtb_round_robin_out, dcache_enable_out, dcache_size_16k_out});
    chk("parity_off", 64'h0, {62'h0, icache_parity_check_en_out, dcache_parity_check_en_out});
    chk("no_flush", 64'h0, 64'(dcache_flush_out));
    wr_ctl(64'h0);
    chk("ctl_clr", 64'h0, {61'h0, dtb_round_robin_out, dcache_enable_out, dcache_size_16k_out});
    chk("flush", 64'h1, 64'(dcache_flush_out));
    chk("parity_on", 64'h3, {62'h0, icache_parity_check_en_out, dcache_parity_check_en_out});
    rd_chk(LSUC_IPR_LSU_CTL, 64'h0);
    $display("test reset_and_ctl done");
  endtask : t_reset_and_ctl

  task automatic t_lookups();
    wr_ctl((64'h1 << LSUC_CTL_FHIT_BIT) | (64'h1 << LSUC_CTL_FTAG_BIT) | (64'h1 << LSUC_CTL_NOPROBE_BIT));
    lookups(1'h0, 1'h0, 1'h1, 3'h7);
    lookups(1'h0, 1'h1, 1'h1, 3'h4);
    wr_ctl(64'h1 << LSUC_CTL_DATA_CACHE_ENABLE_BIT);
    lookups(1'h0, 1'h1, 1'h1, 3'h2);
    lookups(1'h1, 1'h0, 1'h1, 3'h4);
    $display("test lookups done");
  endtask : t_lookups

  task automatic t_lock(input logic relax);
    wr_ctl(64'(relax) << LSUC_CTL_STC_BIT);
    chk("lock_conforming", 64'(!relax), 64'(lock_conforming_out));
    chk("unpredictable", 64'(relax), 64'(cond_result_unpredictable_out));
    @(posedge clk_sys_in);
    locked_op_valid_in <= 1'h1;
    locked_op_addr_in <= 34'h2_A5A5_5A50;
    @(posedge clk_sys_in);
    locked_op_valid_in <= 1'h0;
    cond_store_to_biu_in <= 1'h1;
    #1;
    chk("line_inval", 64'(relax), 64'(dc_line_inval_out));
    chk("hidden_1", 64'(relax), 64'(inval_hidden_out));
    if (relax) chk("line_addr", 64'h2_A5A5_5A50, 64'(dc_line_addr_out));
    @(posedge clk_sys_in);
    cond_store_to_biu_in <= 1'h0;
    #1;
    chk("hidden_2", 64'(relax), 64'(inval_hidden_out));
    chk("inval_once", 64'h0, 64'(dc_line_inval_out));
    chk("restart", 64'(relax), 64'(mem_pipe_restart_out));
    @(posedge clk_sys_in);
    #1;
    chk("hidden_end", 64'h0, 64'(inval_hidden_out));
    $display("test lock relax=%0d done", relax);
  endtask : t_lock

  task automatic t_alternate_access_mode();
    for (int m = 0; m < 4; m++) begin
      ipr(1'h1, 1'h0, LSUC_IPR_ALTERNATE_ACCESS_MODE, 64'(m) << LSUC_ALT_LSB);
      for (int a = 0; a < 2; a++) begin
        @(posedge clk_sys_in);
        priv_mem_valid_in <= 1'h1;
        priv_instr_in <= 16'(a) << LSUC_ALT_INSTR_BIT;
        current_mode_in <= lsuc_mode_e'(2'(3 - m));
        @(posedge clk_sys_in);
        priv_mem_valid_in <= 1'h0;
        #1;
        chk("access_mode", 64'(a ? m : 3 - m), 64'(access_mode_out));
      end
    end
    $display("test alternate_access_mode done");
  endtask : t_alternate_access_mode

  task automatic pin(input logic [1:0] line, input logic [7:0] a, input logic [1:0] e);
    logic [1:0] got;
    got = 2'h0;
    @(posedge clk_sys_in);
    invalidate_address_in <= a;
    external_invalidate_request_in <= line;
    for (int i = 0; i < 8 && got === 2'h0; i++) begin
      @(posedge clk_sys_in);
      #1;
      got = dc_block_inval_out;
    end
    if (got === 2'h0) begin
      bad_count++;
      give_verdict();
    end
    chk("blk_inval", 64'(e), 64'(got));
    chk("blk_index", 64'(a), 64'(dc_block_index_out));
    @(posedge clk_sys_in);
    external_invalidate_request_in <= 2'h0;
    repeat (6) @(posedge clk_sys_in);
  endtask : pin

  task automatic t_inval();
    wr_ctl(64'h0);
    pin(2'h1, 8'hA5, 2'h1);
    pin(2'h2, 8'h3C, 2'h2);
    wr_ctl(64'h1 << LSUC_CTL_DINV_BIT);
    pin(2'h1, 8'hFF, 2'h3);
    $display("test inval done");
  endtask : t_inval

  task automatic t_counter();
    ipr(1'h1, 1'h0, LSUC_IPR_CYCLE_COUNTER_CONTROL, 64'h0000_0001_0000_0010);
    @(posedge clk_sys_in);
    #1;
    chk("counting_on", 64'h1, 64'(cycle_counting_out));
    rd_chk(LSUC_IPR_CC, 64'h0000_0000_0000_0012);
    ipr(1'h1, 1'h0, LSUC_IPR_CYCLE_COUNTER_CONTROL, 64'hFFFF_FFFE_0000_0040);
    ipr(1'h1, 1'h0, LSUC_IPR_CC, 64'h1234_5678_DEAD_BEE0);
    rd_chk(LSUC_IPR_CC, 64'h1234_5678_0000_0040);
    chk("counting_off", 64'h0, 64'(cycle_counting_out));
    repeat (10) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    read_cycle_count_instr_in <= 1'h1;
    @(posedge clk_sys_in);
    read_cycle_count_instr_in <= 1'h0;
    #1;
    chk("user_valid", 64'h1, 64'(read_valid_out));
    chk("user_read", 64'h1234_5678_0000_0040, read_data_out);
    ipr(1'h1, 1'h0, LSUC_IPR_CYCLE_COUNTER_CONTROL, 64'h0000_0001_FFFF_FFF0);
    repeat (20) @(posedge clk_sys_in);
    rd_chk(LSUC_IPR_CC, 64'h1234_5678_0000_0005);
    $display("test counter done");
  endtask : t_counter

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    @(posedge clk_sys_in);
    #1;
    t_reset_and_ctl();
    t_lookups();
    t_lock(1'h1);
    t_lock(1'h0);
    t_alternate_access_mode();
    t_inval();
    t_counter();
    give_verdict();
  end

endmodule : test_lsuc_regs
